// ===== src/gac_defs.vh
// register map, field layout, reset values and timing for the converter control block
//
// What this block does
// - device self-clears start bit; reads as busy
// - conversion completes 350 us after start
// - result readable in value register after busy
// - input select 000 picks temperature sensor
// - reset reference is bandgap, 4 mV steps
// - reference select scales step size proportionally
// - differential mode takes inputs from two pins
// - gain codes set 22/13..88/13, 1.5x with ref0
// - gain codes map 16.7..4.2 percent to 255
// - offset: +low3 or -(8-low3) times 0.12 percent, zero for code 0000
// - differential mode unipolar, results unsigned
`ifndef GAC_DEFS_VH
`define GAC_DEFS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define GAC_ADDR_W          7
`define GAC_OFFS_CONFIG     7'h0f
`define GAC_OFFS_AMP_OFFSET 7'h10
`define GAC_OFFS_RESULT     7'h11

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define GAC_CFG_START_BIT   7
`define GAC_CFG_SEL_HI      6
`define GAC_CFG_SEL_LO      4
`define GAC_CFG_REF_HI      3
`define GAC_CFG_REF_LO      2
`define GAC_CFG_GAIN_HI     1
`define GAC_CFG_GAIN_LO     0
`define GAC_OFS_HI          3
`define GAC_OFS_LO          0
`define GAC_CFG_RESET       8'h00
`define GAC_OFS_RESET       8'h00
`define GAC_RESULT_RESET    8'h00

// ----------------------------------------------------------------------------
// input and reference codes
// ----------------------------------------------------------------------------
`define GAC_SEL_TEMP        3'b000
`define GAC_SEL_DIFF        3'b110
`define GAC_REF_BANDGAP     2'b00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define GAC_CLK_MHZ         100
`define GAC_CONV_TIME_US    350
`define GAC_CONV_CYCLES     (`GAC_CONV_TIME_US * `GAC_CLK_MHZ)
`define GAC_SETTLE_TIME_NS  1000
`define GAC_SETTLE_CYCLES   ((`GAC_SETTLE_TIME_NS * `GAC_CLK_MHZ) / 1000)
`define GAC_CNT_W           16

`endif

// ===== src/gac_sar.v
// successive-approximation sequencer: eight trials against the comparator
`include "gac_defs.vh"

module gac_sar (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       start_i,
  input  wire       comp_i,
  output reg  [7:0] code_o,
  output reg        done_o
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_TRIAL = 2'b10;
  localparam integer          SETTLE_INT  = `GAC_SETTLE_CYCLES - 1;
  localparam [`GAC_CNT_W-1:0] SETTLE_LAST = SETTLE_INT[`GAC_CNT_W-1:0];

  reg [1:0]            state_r;
  reg [2:0]            bit_r;
  reg [`GAC_CNT_W-1:0] wait_r;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      bit_r   <= 3'd7;
      wait_r  <= {`GAC_CNT_W{1'b0}};
      code_o  <= 8'h00;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_i) begin
            code_o  <= 8'h80;
            bit_r   <= 3'd7;
            wait_r  <= {`GAC_CNT_W{1'b0}};
            state_r <= ST_TRIAL;
          end
        end
        ST_TRIAL: begin
          if (wait_r == SETTLE_LAST) begin
            wait_r <= {`GAC_CNT_W{1'b0}};
            // comparator low means the trial code overshot: drop the bit
            if (!comp_i)
              code_o[bit_r] <= 1'b0;
            if (bit_r == 3'd0) begin
              done_o  <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              code_o[bit_r - 3'd1] <= 1'b1;
              bit_r <= bit_r - 3'd1;
            end
          end else begin
            wait_r <= wait_r + {{(`GAC_CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // gac_sar

// ===== src/gac_ctrl.v
// converter control: register port, conversion timing, analog selects
`include "gac_defs.vh"

module gac_ctrl #(
  parameter [`GAC_CNT_W-1:0] CONV_CYCLES = `GAC_CONV_CYCLES
) (
  input  wire                   REF_CLK_I,
  input  wire                   RST_N_I,
  input  wire [`GAC_ADDR_W-1:0] ADDR_I,
  input  wire [7:0]             WDATA_I,
  input  wire                   WR_EN_I,
  input  wire                   RD_EN_I,
  output reg  [7:0]             RDATA_O,
  input  wire                   COMP_I,
  output wire [7:0]             DAC_CODE_O,
  output wire                   SAMPLE_EN_O,
  output wire [2:0]             INPUT_SEL_O,
  output wire                   TEMP_SENSE_EN_O,
  output wire                   DIFF_PINS_EN_O,
  output wire [1:0]             REF_SEL_O,
  output wire [1:0]             GAIN_SEL_O,
  output wire                   GAIN_X15_O,
  output wire [3:0]             OFFS_STEPS_O,
  output wire                   BUSY_O
);

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  function hit;
    input [`GAC_ADDR_W-1:0] addr;
    input [`GAC_ADDR_W-1:0] offs;
    begin
      hit = (addr == offs);
    end
  endfunction

  function sel_is;
    input [2:0] sel;
    input [2:0] code;
    begin
      sel_is = (sel == code);
    end
  endfunction

  // signed offset steps of 0.12 percent of supply, two's complement
  function [3:0] offs_steps;
    input [3:0] code;
    begin
      if (code[3])
        offs_steps = {1'b0, code[2:0]};
      else if (code[2:0] == 3'b000)
        offs_steps = 4'h0;
      else
        offs_steps = {1'b1, code[2:0]};
    end
  endfunction

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  localparam [7:0] CFG_RST   = `GAC_CFG_RESET;
  localparam [7:0] OFS_RST   = `GAC_OFS_RESET;
  localparam [3:0] STEPS_RST = offs_steps(OFS_RST[3:0]);
  localparam [0:0] TEMP_RST  = sel_is(CFG_RST[`GAC_CFG_SEL_HI:`GAC_CFG_SEL_LO], `GAC_SEL_TEMP);
  localparam [0:0] DIFF_RST  = sel_is(CFG_RST[`GAC_CFG_SEL_HI:`GAC_CFG_SEL_LO], `GAC_SEL_DIFF);

  reg [6:0]            cfg_r;
  reg [6:0]            cfg_nxt;
  reg                  busy_r;
  reg [3:0]            ofs_r;
  reg [3:0]            ofs_nxt;
  reg [7:0]            result_r;
  reg [7:0]            rdata_nxt;
  reg [`GAC_CNT_W-1:0] timer_r;
  reg                  time_up_r;
  reg                  sar_done_r;
  reg                  sar_start_r;
  reg                  comp_meta_r;
  reg                  comp_sync_r;
  reg                  temp_en_r;
  reg                  diff_en_r;
  reg [3:0]            offs_steps_r;

  wire       wr_cfg     = WR_EN_I && hit(ADDR_I, `GAC_OFFS_CONFIG);
  wire       wr_ofs     = WR_EN_I && hit(ADDR_I, `GAC_OFFS_AMP_OFFSET);
  wire       start_req  = wr_cfg && WDATA_I[`GAC_CFG_START_BIT] && !busy_r;
  wire [7:0] sar_code;
  wire       sar_done;
  wire [7:0] cfg_view   = {busy_r, cfg_r};
  wire [2:0] sel_nxt    = cfg_nxt[`GAC_CFG_SEL_HI:`GAC_CFG_SEL_LO];
  wire       timer_last = (timer_r == CONV_CYCLES - 1'b1);
  wire       finish     = busy_r && (time_up_r || timer_last) && (sar_done_r || sar_done);

  // --------------------------------------------------------------------------
  // comparator synchroniser
  // --------------------------------------------------------------------------
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      comp_meta_r <= 1'b0;
      comp_sync_r <= 1'b0;
    end else begin
      comp_meta_r <= COMP_I;
      comp_sync_r <= comp_meta_r;
    end
  end

  // --------------------------------------------------------------------------
  // configuration and offset registers
  // --------------------------------------------------------------------------
  // field writes land even while busy; the running conversion keeps going
  always @* begin
    cfg_nxt = cfg_r;
    ofs_nxt = ofs_r;
    if (wr_cfg)
      cfg_nxt = WDATA_I[6:0];
    if (wr_ofs)
      ofs_nxt = WDATA_I[`GAC_OFS_HI:`GAC_OFS_LO];
  end

  // decoded selects and offset steps follow the next field values,
  // so they change on the same edge as the fields themselves
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_r        <= CFG_RST[6:0];
      ofs_r        <= OFS_RST[3:0];
      temp_en_r    <= TEMP_RST;
      diff_en_r    <= DIFF_RST;
      offs_steps_r <= STEPS_RST;
    end else begin
      cfg_r        <= cfg_nxt;
      ofs_r        <= ofs_nxt;
      temp_en_r    <= sel_is(sel_nxt, `GAC_SEL_TEMP);
      diff_en_r    <= sel_is(sel_nxt, `GAC_SEL_DIFF);
      offs_steps_r <= offs_steps(ofs_nxt);
    end
  end

  // --------------------------------------------------------------------------
  // conversion timing and busy
  // --------------------------------------------------------------------------
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_r      <= 1'b0;
      timer_r     <= {`GAC_CNT_W{1'b0}};
      time_up_r   <= 1'b0;
      sar_done_r  <= 1'b0;
      sar_start_r <= 1'b0;
      result_r    <= `GAC_RESULT_RESET;
    end else begin
      sar_start_r <= start_req;
      if (start_req) begin
        busy_r     <= 1'b1;
        timer_r    <= {`GAC_CNT_W{1'b0}};
        time_up_r  <= 1'b0;
        sar_done_r <= 1'b0;
      end else if (finish) begin
        busy_r   <= 1'b0;
        result_r <= sar_code;
      end else if (busy_r) begin
        if (timer_r == CONV_CYCLES - 1'b1)
          time_up_r <= 1'b1;
        else
          timer_r <= timer_r + {{(`GAC_CNT_W-1){1'b0}}, 1'b1};
        if (sar_done)
          sar_done_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // successive-approximation sequencer
  // --------------------------------------------------------------------------
  gac_sar u_sar (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .start_i (sar_start_r),
    .comp_i  (comp_sync_r),
    .code_o  (sar_code),
    .done_o  (sar_done)
  );

  // --------------------------------------------------------------------------
  // register read port
  // --------------------------------------------------------------------------
  // unmapped addresses read as zero; read data stands until the next read
  always @* begin
    rdata_nxt = RDATA_O;
    if (RD_EN_I) begin
      if (hit(ADDR_I, `GAC_OFFS_CONFIG))
        rdata_nxt = cfg_view;
      else if (hit(ADDR_I, `GAC_OFFS_AMP_OFFSET))
        rdata_nxt = {4'h0, ofs_r};
      else if (hit(ADDR_I, `GAC_OFFS_RESULT))
        rdata_nxt = result_r;
      else
        rdata_nxt = 8'h00;
    end
  end

  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 8'h00;
    end else begin
      RDATA_O <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // analog front-end selects
  // --------------------------------------------------------------------------
  assign DAC_CODE_O      = sar_code;
  assign SAMPLE_EN_O     = busy_r;
  assign BUSY_O          = busy_r;
  assign INPUT_SEL_O     = cfg_r[`GAC_CFG_SEL_HI:`GAC_CFG_SEL_LO];
  assign TEMP_SENSE_EN_O = temp_en_r;
  assign DIFF_PINS_EN_O  = diff_en_r;
  // reset value 00 selects the bandgap; other codes rescale the step
  assign REF_SEL_O       = cfg_r[`GAC_CFG_REF_HI:`GAC_CFG_REF_LO];
  assign GAIN_SEL_O      = cfg_r[`GAC_CFG_GAIN_HI:`GAC_CFG_GAIN_LO];
  // ref bit 0 raises gain by 1.5 so the span stays fixed
  assign GAIN_X15_O      = cfg_r[`GAC_CFG_REF_LO];
  // unipolar result: offset lifts negative bridge offset into range
  assign OFFS_STEPS_O    = offs_steps_r;

endmodule // gac_ctrl

// ===== bench/gac_ctrl_sva.sv
// assertion checker for the converter control block
`include "gac_defs.vh"
module gac_ctrl_sva #(
  parameter [`GAC_CNT_W-1:0] CONV_CYCLES = `GAC_CONV_CYCLES
) (
  input logic                   REF_CLK_I,
  input logic                   RST_N_I,
  input logic [`GAC_ADDR_W-1:0] ADDR_I,
  input logic [7:0]             WDATA_I,
  input logic                   WR_EN_I,
  input logic                   RD_EN_I,
  input logic [7:0]             RDATA_O,
  input logic [7:0]             DAC_CODE_O,
  input logic [2:0]             INPUT_SEL_O,
  input logic                   TEMP_SENSE_EN_O,
  input logic                   DIFF_PINS_EN_O,
  input logic [1:0]             REF_SEL_O,
  input logic [1:0]             GAIN_SEL_O,
  input logic                   GAIN_X15_O,
  input logic [3:0]             OFFS_STEPS_O,
  input logic                   SAMPLE_EN_O,
  input logic                   BUSY_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // ----------------------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------------------
  logic [15:0] busy_cnt_r;
  wire         cfg_wr  = WR_EN_I && (ADDR_I == `GAC_OFFS_CONFIG);
  wire         ofs_wr  = WR_EN_I && (ADDR_I == `GAC_OFFS_AMP_OFFSET);
  wire [3:0]   ofs_exp = WDATA_I[3] ? {1'b0, WDATA_I[2:0]} :
                         ((WDATA_I[2:0] == 3'h0) ? 4'h0 : {1'b1, WDATA_I[2:0]});
  // counts cycles of a running conversion
  always @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= BUSY_O ? busy_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  a_start_sets_busy: assert property (cfg_wr && WDATA_I[7] && !BUSY_O |=> BUSY_O)
    else $error("start write did not raise busy");
  a_sample_busy: assert property (SAMPLE_EN_O == BUSY_O)
    else $error("sample enable differs from busy");
  a_busy_length: assert property ($fell(BUSY_O) |-> busy_cnt_r == CONV_CYCLES)
    else $error("conversion length wrong");
  a_first_trial: assert property ($rose(BUSY_O) |=> DAC_CODE_O == 8'h80)
    else $error("first trial code wrong");
  a_busy_readback: assert property (RD_EN_I && ADDR_I == `GAC_OFFS_CONFIG |=>
    RDATA_O[7] == $past(BUSY_O))
    else $error("busy bit readback wrong");
  a_rdata_holds: assert property (!RD_EN_I |=> $stable(RDATA_O))
    else $error("read data changed without read");
  a_cfg_fields: assert property (cfg_wr |=>
    {INPUT_SEL_O, REF_SEL_O, GAIN_SEL_O} == $past(WDATA_I[6:0]))
    else $error("configuration fields wrong");
  a_gain_boost: assert property (GAIN_X15_O == REF_SEL_O[0])
    else $error("gain boost not tied to reference bit");
  a_temp_select: assert property (TEMP_SENSE_EN_O == (INPUT_SEL_O == `GAC_SEL_TEMP))
    else $error("temperature select wrong");
  a_diff_select: assert property (DIFF_PINS_EN_O == (INPUT_SEL_O == `GAC_SEL_DIFF))
    else $error("differential select wrong");
  a_offset_map: assert property (ofs_wr |=> OFFS_STEPS_O == $past(ofs_exp))
    else $error("offset steps wrong");
endmodule // gac_ctrl_sva

bind gac_ctrl gac_ctrl_sva #(.CONV_CYCLES(CONV_CYCLES)) u_sva (
  .REF_CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_EN_I, .RD_EN_I, .RDATA_O, .DAC_CODE_O,
  .INPUT_SEL_O, .TEMP_SENSE_EN_O, .DIFF_PINS_EN_O, .REF_SEL_O, .GAIN_SEL_O, .GAIN_X15_O,
  .OFFS_STEPS_O, .SAMPLE_EN_O, .BUSY_O);

// ===== bench/gac_ctrl_tb_top.sv
// self-checking testbench for the converter control block
`include "gac_defs.vh"
module gac_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV = 900;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       comp  = 1'b0;
  logic [6:0] addr  = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] vin   = 8'hA5;
  wire  [7:0] rdata, dac;
  wire  [1:0] rsel, gsel;
  wire  [3:0] ofs;
  wire        busy, temp, diff, x15;
  int         err_count = 0;
  int         comparisons = 0;
  int         n;

  always #5 clk = ~clk;
  // analog input seen through the converter's comparator
  always @(posedge clk) comp <= (vin >= dac);

  gac_ctrl #(.CONV_CYCLES(16'(CONV))) uut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_EN_I(wr),
    .RD_EN_I(rd), .RDATA_O(rdata), .COMP_I(comp), .DAC_CODE_O(dac), .SAMPLE_EN_O(),
    .INPUT_SEL_O(), .TEMP_SENSE_EN_O(temp), .DIFF_PINS_EN_O(diff), .REF_SEL_O(rsel),
    .GAIN_SEL_O(gsel), .GAIN_X15_O(x15), .OFFS_STEPS_O(ofs), .BUSY_O(busy));

  // ----------------------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic chk_rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic wait_idle(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (busy === 1'b1 && k < 2000);
    if (k >= 2000) begin
      err_count++;
      $display("[ERR] %0t busy never cleared", $time);
      end_sim();
    end
  endtask

  // offset steps: +low3 with the top bit set, else -(8 - low3), zero when low3 is zero
  function automatic logic [3:0] ofs_ref(input logic [3:0] c);
    int s;
    if (c[3])
      s = int'(c[2:0]);
    else if (c[2:0] == 3'h0)
      s = 0;
    else
      s = -(8 - int'(c[2:0]));
    return 4'(s);
  endfunction

  // ----------------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd(`GAC_OFFS_CONFIG, 8'h00);
    chk({6'h00, rsel}, 8'h00);
    chk({7'h00, temp}, 8'h01);
    chk_rd(`GAC_OFFS_AMP_OFFSET, 8'h00);
    chk_rd(`GAC_OFFS_RESULT, 8'h00);
    chk_rd(7'h12, 8'h00);
    wr_reg(`GAC_OFFS_CONFIG, 8'h80);
    wait_idle(n);
    chk({7'h00, (n == CONV)}, 8'h01);
    chk_rd(`GAC_OFFS_RESULT, 8'hA5);
    vin <= 8'h3C;
    chk_rd(`GAC_OFFS_RESULT, 8'hA5);
    // bridge setup: input first, then reference code 10 taken as half supply
    wr_reg(`GAC_OFFS_CONFIG, 8'h60);
    wr_reg(`GAC_OFFS_CONFIG, 8'h68);
    wr_reg(`GAC_OFFS_CONFIG, 8'hE8);
    chk_rd(`GAC_OFFS_CONFIG, 8'hE8);
    chk({7'h00, diff}, 8'h01);
    chk({7'h00, temp}, 8'h00);
    // clearing the start bit mid-run must not abort
    wr_reg(`GAC_OFFS_CONFIG, 8'h68);
    chk_rd(`GAC_OFFS_CONFIG, 8'hE8);
    chk_rd(`GAC_OFFS_RESULT, 8'hA5);
    wait_idle(n);
    chk_rd(`GAC_OFFS_CONFIG, 8'h68);
    // raw value: fine offset correction is left to software
    chk_rd(`GAC_OFFS_RESULT, 8'h3C);
    wr_reg(`GAC_OFFS_RESULT, 8'h00);
    chk_rd(`GAC_OFFS_RESULT, 8'h3C);
    for (int i = 0; i < 16; i++) begin
      wr_reg(`GAC_OFFS_CONFIG, {4'h6, i[3:0]});
      wr_reg(`GAC_OFFS_AMP_OFFSET, {4'hF, i[3:0]});
      chk_rd(`GAC_OFFS_AMP_OFFSET, {4'h0, i[3:0]});
      chk({4'h0, rsel, gsel}, {4'h0, i[3:0]});
      chk({7'h00, x15}, {7'h00, i[2]});
      chk({4'h0, ofs}, {4'h0, ofs_ref(i[3:0])});
    end
    end_sim();
  end
endmodule // gac_ctrl_tb_top
